// >>> src/spa_pkg.sv
package spa_pkg;

  // Word offsets of the remote registers written by the master
  localparam logic [4:0] OFS_DIR = 5'h10;
  localparam logic [4:0] OFS_ID = 5'h11;
  localparam logic [4:0] OFS_BULK = 5'h18;

  // Access direction encodings
  localparam logic [15:0] DIR_READ = 16'h0000;
  localparam logic [15:0] DIR_WRITE = 16'h0001;

  // Target identifier ranges
  localparam logic [15:0] ID_OUT_LO = 16'h0000;
  localparam logic [15:0] ID_OUT_HI = 16'h00FF;
  localparam logic [15:0] ID_IN_LO = 16'h0200;
  localparam logic [15:0] ID_IN_HI = 16'h02FF;

  // Bulk status group commands
  localparam logic [15:0] BULK_FIRST = 16'h0040;
  localparam logic [15:0] BULK_LAST = 16'h0043;

  // Fixed message header words and size
  localparam logic [15:0] HDR_LEAD = 16'h0002;
  localparam logic [15:0] HDR_READ = 16'h1504;
  localparam logic [15:0] HDR_WRITE = 16'h1505;
  localparam logic [15:0] HDR_TAIL = 16'h0000;
  localparam logic [15:0] MSG_SIZE = 16'h0026;

  // Error information codes
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_DIR = 16'h0001;
  localparam logic [15:0] ERR_ID = 16'h0002;
  localparam logic [15:0] ERR_BUSY = 16'h0003;
  localparam logic [15:0] ERR_HDR = 16'h0004;
  localparam logic [15:0] ERR_CMD = 16'h0005;
  localparam logic [15:0] ERR_TIMEOUT = 16'h0006;
  localparam logic [15:0] ERR_FAIL = 16'h0007;
  localparam logic [15:0] ERR_ALARM = 16'h0008;

  // Slave answer wait, in clock cycles
  localparam int SLV_TIMEOUT_CYC = 1000;
  localparam int TMO_W = 12;

  // Reset values
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [TMO_W-1:0] CNT_RST = 12'h000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01
  } spa_state_e;

  // Controller state
  typedef struct packed {
    spa_state_e st;
    logic req_q;
    logic done;
    logic alarm;
    logic err;
    logic [15:0] dir;
    logic [15:0] id;
    logic [15:0] err_code;
    logic [15:0] rdata;
    logic from_msg;
    logic start;
    logic xwr;
    logic xbulk;
    logic [15:0] xsel;
    logic msg_done;
    logic msg_err;
  } spa_ctl_s;

  // Link engine state
  typedef struct packed {
    logic busy;
    logic [TMO_W-1:0] cnt;
    logic done;
    logic alarm;
    logic fail;
    logic tmo;
    logic [15:0] rdata;
    logic req;
    logic wr;
    logic bulk;
    logic [15:0] sel;
  } spa_eng_s;

endpackage

// >>> src/spa_xact_if.sv
`timescale 1ns/10ps
`default_nettype none
interface spa_xact_if;
  logic start;
  logic write;
  logic bulk;
  logic [15:0] sel;
  logic done;
  logic alarm;
  logic fail;
  logic tmo;
  logic [15:0] rdata;

  modport ctl (output start, write, bulk, sel,
               input done, alarm, fail, tmo, rdata);
  modport eng (input start, write, bulk, sel,
               output done, alarm, fail, tmo, rdata);
endinterface
`default_nettype wire

// >>> src/spa_link_engine.sv
`timescale 1ns/10ps
`default_nettype none
module spa_link_engine
  import spa_pkg::*;
#(
  parameter int TIMEOUT_CYC = SLV_TIMEOUT_CYC
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Controller side
  spa_xact_if.eng x,
  // Downstream slave network
  output logic slv_req,
  output logic slv_write,
  output logic slv_bulk,
  output logic [15:0] slv_sel,
  input wire logic slv_ack,
  input wire logic slv_alarm,
  input wire logic slv_fail,
  input wire logic [15:0] slv_rdata
);

  localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(TIMEOUT_CYC - 1);

  spa_eng_s r_reg;
  spa_eng_s r_next;

  // One transaction at a time; a silent slave is cut off by the timer
  always_comb
  begin
    r_next = r_reg;
    r_next.done = 1'b0;
    if (!r_reg.busy && x.start)
    begin
      r_next.busy = 1'b1;
      r_next.req = 1'b1;
      r_next.cnt = CNT_RST;
      r_next.wr = x.write;
      r_next.bulk = x.bulk;
      r_next.sel = x.sel;
    end
    else if (r_reg.busy)
    begin
      if (slv_ack)
      begin
        r_next.busy = 1'b0;
        r_next.req = 1'b0;
        r_next.done = 1'b1;
        r_next.alarm = slv_alarm;
        r_next.fail = slv_fail;
        r_next.tmo = 1'b0;
        r_next.rdata = slv_rdata;
      end
      else if (r_reg.cnt == TMO_LAST)
      begin
        r_next.busy = 1'b0;
        r_next.req = 1'b0;
        r_next.done = 1'b1;
        r_next.alarm = 1'b0;
        r_next.fail = 1'b0;
        r_next.tmo = 1'b1;
      end
      else
      begin
        r_next.cnt = r_reg.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      r_reg <= '0;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // Results and pins straight from flip-flops
  assign x.done = r_reg.done;
  assign x.alarm = r_reg.alarm;
  assign x.fail = r_reg.fail;
  assign x.tmo = r_reg.tmo;
  assign x.rdata = r_reg.rdata;
  assign slv_req = r_reg.req;
  assign slv_write = r_reg.wr;
  assign slv_bulk = r_reg.bulk;
  assign slv_sel = r_reg.sel;

endmodule
`default_nettype wire

// >>> src/spa_param_access.sv
`timescale 1ns/10ps
`default_nettype none
module spa_param_access
  import spa_pkg::*;
#(
  parameter int TIMEOUT_CYC = SLV_TIMEOUT_CYC
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Remote bits from the master
  input wire logic access_request_bit,
  input wire logic error_clear_request,
  // Remote register writes from the master
  input wire logic rww_wr,
  input wire logic [4:0] rww_addr,
  input wire logic [15:0] rww_wdata,
  // Message transaction from the master
  input wire logic msg_req,
  input wire logic [15:0] msg_hdr_lead,
  input wire logic [15:0] msg_hdr_kind,
  input wire logic [15:0] msg_hdr_tail,
  input wire logic [15:0] msg_target,
  input wire logic [15:0] msg_size,
  output logic msg_done,
  output logic msg_err,
  // Remote bits and words to the master
  output logic access_done_flag,
  output logic slave_alarm_flag,
  output logic access_error_flag,
  output logic [15:0] error_info_word,
  output logic [15:0] read_data_word,
  // Downstream slave network
  output logic slv_req,
  output logic slv_write,
  output logic slv_bulk,
  output logic [15:0] slv_sel,
  input wire logic slv_ack,
  input wire logic slv_alarm,
  input wire logic slv_fail,
  input wire logic [15:0] slv_rdata
);

  spa_xact_if xif ();

  spa_ctl_s r_reg;
  spa_ctl_s r_next;

  logic req_rise;
  logic bulk_go;
  logic id_ok;
  logic msg_id_ok;
  logic msg_hdr_ok;

  function automatic logic id_in_range(input logic [15:0] v);
    id_in_range = (v >= ID_OUT_LO && v <= ID_OUT_HI) ||
                  (v >= ID_IN_LO && v <= ID_IN_HI);
  endfunction

  // Held request would otherwise relaunch after every completion
  assign req_rise = access_request_bit && !r_reg.req_q;
  assign bulk_go = rww_wr && (rww_addr == OFS_BULK);
  assign id_ok = id_in_range(r_reg.id);
  assign msg_id_ok = id_in_range(msg_target);
  // Header check covers both directions of the message form
  assign msg_hdr_ok = (msg_hdr_lead == HDR_LEAD) &&
                      (msg_hdr_tail == HDR_TAIL) &&
                      (msg_size == MSG_SIZE) &&
                      (msg_hdr_kind == HDR_READ ||
                       msg_hdr_kind == HDR_WRITE);

  always_comb
  begin
    r_next = r_reg;
    r_next.req_q = access_request_bit;
    r_next.start = 1'b0;
    r_next.msg_done = 1'b0;
    r_next.msg_err = 1'b0;

    // Error reset; any set below in the same cycle wins
    if (error_clear_request)
    begin
      r_next.alarm = 1'b0;
      r_next.err = 1'b0;
    end

    // Direction and target words for the bit-driven access
    if (rww_wr && rww_addr == OFS_DIR)
    begin
      r_next.dir = rww_wdata;
    end
    if (rww_wr && rww_addr == OFS_ID)
    begin
      r_next.id = rww_wdata;
    end

    unique case (r_reg.st)
      ST_IDLE:
      begin
        if (req_rise)
        begin
          r_next.done = 1'b0;
          r_next.from_msg = 1'b0;
          if (r_reg.dir != DIR_READ && r_reg.dir != DIR_WRITE)
          begin
            r_next.done = 1'b1;
            r_next.err = 1'b1;
            r_next.err_code = ERR_DIR;
          end
          else if (!id_ok)
          begin
            r_next.done = 1'b1;
            r_next.err = 1'b1;
            r_next.err_code = ERR_ID;
          end
          else
          begin
            r_next.st = ST_RUN;
            r_next.start = 1'b1;
            r_next.xwr = (r_reg.dir == DIR_WRITE);
            r_next.xbulk = 1'b0;
            r_next.xsel = r_reg.id;
          end
          if (msg_req)
          begin
            r_next.msg_done = 1'b1;
            r_next.msg_err = 1'b1;
          end
        end
        else if (msg_req)
        begin
          r_next.done = 1'b0;
          r_next.from_msg = 1'b1;
          if (!msg_hdr_ok || !msg_id_ok)
          begin
            r_next.done = 1'b1;
            r_next.err = 1'b1;
            r_next.err_code = msg_hdr_ok ? ERR_ID : ERR_HDR;
            r_next.msg_done = 1'b1;
            r_next.msg_err = 1'b1;
          end
          else
          begin
            r_next.st = ST_RUN;
            r_next.start = 1'b1;
            r_next.xwr = (msg_hdr_kind == HDR_WRITE);
            r_next.xbulk = 1'b0;
            r_next.xsel = msg_target;
          end
        end
        else if (bulk_go)
        begin
          r_next.done = 1'b0;
          r_next.from_msg = 1'b0;
          if (rww_wdata < BULK_FIRST || rww_wdata > BULK_LAST)
          begin
            r_next.done = 1'b1;
            r_next.err = 1'b1;
            r_next.err_code = ERR_CMD;
          end
          else
          begin
            r_next.st = ST_RUN;
            r_next.start = 1'b1;
            r_next.xwr = 1'b0;
            r_next.xbulk = 1'b1;
            r_next.xsel = rww_wdata;
          end
        end
      end
      ST_RUN:
      begin
        // Only one access may be open; a message arriving meanwhile is turned away, but a same-cycle completion overwrites that reply
        if (msg_req)
        begin
          r_next.msg_done = 1'b1;
          r_next.msg_err = 1'b1;
        end
        if (xif.done)
        begin
          r_next.st = ST_IDLE;
          r_next.done = 1'b1;
          r_next.msg_done = r_reg.from_msg;
          r_next.msg_err = 1'b0;
          if (xif.alarm)
          begin
            r_next.alarm = 1'b1;
            r_next.err_code = ERR_ALARM;
            r_next.msg_err = r_reg.from_msg;
          end
          else if (xif.fail || xif.tmo)
          begin
            r_next.err = 1'b1;
            r_next.err_code = xif.tmo ? ERR_TIMEOUT : ERR_FAIL;
            r_next.msg_err = r_reg.from_msg;
          end
          else if (!r_reg.xwr)
          begin
            r_next.rdata = xif.rdata;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      r_reg <= '0;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // Transaction request to the link engine
  assign xif.start = r_reg.start;
  assign xif.write = r_reg.xwr;
  assign xif.bulk = r_reg.xbulk;
  assign xif.sel = r_reg.xsel;

  spa_link_engine #(
    .TIMEOUT_CYC(TIMEOUT_CYC)
  ) u_eng (
    .clk(clk),
    .rst_b(rst_b),
    .x(xif),
    .slv_req(slv_req),
    .slv_write(slv_write),
    .slv_bulk(slv_bulk),
    .slv_sel(slv_sel),
    .slv_ack(slv_ack),
    .slv_alarm(slv_alarm),
    .slv_fail(slv_fail),
    .slv_rdata(slv_rdata)
  );

  // Flags and words toward the master, all registered
  assign access_done_flag = r_reg.done;
  assign slave_alarm_flag = r_reg.alarm;
  assign access_error_flag = r_reg.err;
  assign error_info_word = r_reg.err_code;
  assign read_data_word = r_reg.rdata;
  assign msg_done = r_reg.msg_done;
  assign msg_err = r_reg.msg_err;

endmodule
`default_nettype wire

// >>> sim/spa_slv_model.sv
`timescale 1ns/10ps
`default_nettype none
module spa_slv_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Answer delay and kind: 0 ok, 1 alarm, 2 fail, 3 silent
  input wire logic [3:0] lat,
  input wire logic [1:0] mode,
  // Slave network
  input wire logic slv_req,
  input wire logic [15:0] slv_sel,
  output logic slv_ack,
  output logic slv_alarm,
  output logic slv_fail,
  output logic [15:0] slv_rdata
);
  logic [3:0] cnt_reg;
  // Count cycles of a pending request
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      cnt_reg <= 4'h0;
    else
      cnt_reg <= (slv_req && !slv_ack) ? cnt_reg + 4'h1 : 4'h0;
  // Silent mode lets the block's own timeout fire
  assign slv_ack = slv_req && cnt_reg == lat && mode != 2'h3;
  assign slv_alarm = slv_ack && mode == 2'h1;
  assign slv_fail = slv_ack && mode == 2'h2;
  // Outside an answer the data lines carry junk, never the last word
  assign slv_rdata = slv_ack ? slv_sel ^ 16'h5a5a : ~(slv_sel ^ 16'h5a5a);
endmodule
`default_nettype wire

// >>> sim/spa_param_access_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module spa_param_access_chk
  import spa_pkg::*;
#(
  parameter int TIMEOUT_CYC = SLV_TIMEOUT_CYC
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Master side
  input wire logic access_request_bit,
  input wire logic error_clear_request,
  input wire logic rww_wr,
  input wire logic msg_req,
  input wire logic access_done_flag,
  input wire logic slave_alarm_flag,
  input wire logic access_error_flag,
  input wire logic [15:0] error_info_word,
  // Slave side
  input wire logic slv_req,
  input wire logic slv_bulk,
  input wire logic [15:0] slv_sel,
  input wire logic slv_ack,
  input wire logic slv_alarm,
  input wire logic slv_fail
);
  wire logic calm;
  wire logic ans;
  logic [12:0] hi_cnt_reg;
  // Cycles slv_req has stood high; cheaper than a long delay range
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hi_cnt_reg <= 13'h0000;
    end
    else
    begin
      hi_cnt_reg <= slv_req ? hi_cnt_reg + 13'h0001 : 13'h0000;
    end
  end
  // Idle with no message or register write that could start or fail an access
  assign calm = access_done_flag && !msg_req && !rww_wr;
  assign ans = slv_req && slv_ack;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_start_clears: assert property ($rose(slv_req)
    |-> !access_done_flag) else $error("done high at start");
  a_ack_done: assert property (ans |=> !slv_req ##1 access_done_flag)
    else $error("no done after ack");
  a_alarm_sets: assert property (ans && slv_alarm |-> ##2
    slave_alarm_flag && error_info_word == ERR_ALARM) else $error("alarm");
  a_fail_sets: assert property (ans && slv_fail && !slv_alarm |-> ##2
    access_error_flag && error_info_word == ERR_FAIL) else $error("fail");
  a_flags_hold: assert property (slave_alarm_flag
    && !error_clear_request |=> slave_alarm_flag) else $error("alarm lost");
  a_err_hold: assert property (access_error_flag
    && !error_clear_request |=> access_error_flag) else $error("error lost");
  a_flags_clear: assert property (error_clear_request && calm
    && !access_request_bit |=> !slave_alarm_flag && !access_error_flag)
    else $error("flags kept");
  a_no_repeat: assert property (calm && access_request_bit
    && $past(access_request_bit) |=> access_done_flag) else $error("repeat");
  a_sel_range: assert property ($rose(slv_req) |-> (slv_bulk ?
    (slv_sel >= BULK_FIRST && slv_sel <= BULK_LAST) : (slv_sel <= ID_OUT_HI
    || (slv_sel >= ID_IN_LO && slv_sel <= ID_IN_HI)))) else $error("target");
  a_req_bound: assert property (hi_cnt_reg <= 13'(TIMEOUT_CYC))
    else $error("no timeout");
endmodule
bind spa_param_access spa_param_access_chk #(.TIMEOUT_CYC(TIMEOUT_CYC))
  spa_param_access_chk_i (.clk, .rst_b, .access_request_bit,
  .error_clear_request, .rww_wr, .msg_req, .access_done_flag,
  .slave_alarm_flag, .access_error_flag, .error_info_word, .slv_req,
  .slv_bulk, .slv_sel, .slv_ack, .slv_alarm, .slv_fail);
`default_nettype wire

// >>> sim/spa_param_access_tb.sv
`timescale 1ns/10ps
`default_nettype none
module spa_param_access_tb;
  import spa_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic access_request_bit = 1'b0;
  logic error_clear_request = 1'b0;
  logic rww_wr = 1'b0;
  logic [4:0] rww_addr = 5'h00;
  logic [15:0] rww_wdata = 16'h0000;
  logic msg_req = 1'b0;
  logic [15:0] msg_hdr_lead = HDR_LEAD;
  logic [15:0] msg_hdr_kind = HDR_READ;
  logic [15:0] msg_hdr_tail = HDR_TAIL;
  logic [15:0] msg_target = 16'h0202;
  logic [15:0] msg_size = MSG_SIZE;
  logic [3:0] lat = 4'h0;
  logic [1:0] mode = 2'h0;
  logic msg_done, msg_err, access_done_flag, slave_alarm_flag;
  logic access_error_flag, slv_req, slv_write, slv_bulk;
  logic slv_ack, slv_alarm, slv_fail;
  logic [15:0] error_info_word, read_data_word, slv_sel, slv_rdata;
  int err_count = 0;
  int n_checks = 0;
  // Short timeout keeps the silent-slave case brief
  spa_param_access #(.TIMEOUT_CYC(8)) spa_param_access_i (.clk, .rst_b,
    .access_request_bit, .error_clear_request, .rww_wr, .rww_addr,
    .rww_wdata, .msg_req, .msg_hdr_lead, .msg_hdr_kind, .msg_hdr_tail,
    .msg_target, .msg_size, .msg_done, .msg_err, .access_done_flag,
    .slave_alarm_flag, .access_error_flag, .error_info_word,
    .read_data_word, .slv_req, .slv_write, .slv_bulk, .slv_sel, .slv_ack,
    .slv_alarm, .slv_fail, .slv_rdata);
  spa_slv_model spa_slv_model_i (.clk, .rst_b, .lat, .mode, .slv_req,
    .slv_sel, .slv_ack, .slv_alarm, .slv_fail, .slv_rdata);
  // 50 MHz clock
  always #10 clk = ~clk;
  task automatic chk(input logic ok, input string m);
    begin
      n_checks++;
      if (ok !== 1'b1)
      begin
        err_count++;
        $display("ERROR %0t: %s", $time, m);
      end
    end
  endtask
  task automatic give_verdict;
    begin
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    begin
      @(posedge clk);
      rww_wr <= 1'b1;
      rww_addr <= a;
      rww_wdata <= d;
      @(posedge clk);
      rww_wr <= 1'b0;
    end
  endtask
  // Bounded wait for the done flag
  task automatic wt;
    int k;
    begin
      k = 0;
      while (access_done_flag !== 1'b1 && k < 40)
      begin
        @(negedge clk);
        k++;
      end
      chk(access_done_flag, "no done");
    end
  endtask
  task automatic go(input logic [15:0] d, input logic [15:0] id,
                    input logic [1:0] m, input logic v);
    begin
      wr(OFS_DIR, d);
      wr(OFS_ID, id);
      mode <= m;
      access_request_bit <= 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      if (v)
        chk(!access_done_flag, "done kept");
      wt();
      if (v)
        chk(slv_write === (d == DIR_WRITE), "direction");
      repeat (3) @(negedge clk);
      chk(access_done_flag, "held request rerun");
      @(posedge clk);
      access_request_bit <= 1'b0;
    end
  endtask
  task automatic clr;
    begin
      @(posedge clk);
      error_clear_request <= 1'b1;
      @(posedge clk);
      error_clear_request <= 1'b0;
      @(negedge clk);
      chk(!slave_alarm_flag && !access_error_flag, "flags kept");
    end
  endtask
  task automatic msg(input logic [15:0] kind, input logic e);
    int k;
    begin
      @(posedge clk);
      msg_req <= 1'b1; // One station only
      msg_hdr_kind <= kind;
      @(posedge clk);
      msg_req <= 1'b0;
      k = 0;
      while (msg_done !== 1'b1 && k < 40)
      begin
        @(negedge clk);
        k++;
      end
      chk(msg_done === 1'b1 && msg_err === e, "message status");
    end
  endtask
  task automatic t_read;
    begin
      go(DIR_READ, 16'h0202, 2'h0, 1'b1);
      chk(read_data_word === 16'h5858, "read data");
      lat <= 4'h3;
      go(DIR_WRITE, 16'h00FF, 2'h0, 1'b1);
      chk(read_data_word === 16'h5858, "write took data");
    end
  endtask
  // Alarm, fail, silence, bad target, bad direction
  task automatic t_err;
    logic [15:0] dv[5] = '{DIR_READ, DIR_WRITE, DIR_READ, DIR_READ, 16'h0002};
    logic [15:0] ids[5] = '{16'h0010, 16'h0200, 16'h02FF, 16'h0100, 16'h0010};
    logic [15:0] cod[5] = '{ERR_ALARM, ERR_FAIL, ERR_TIMEOUT, ERR_ID, ERR_DIR};
    logic [1:0] md[5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
    begin
      for (int i = 0; i < 5; i++)
      begin
        go(dv[i], ids[i], md[i], i < 3);
        chk(error_info_word === cod[i], "error code");
        chk(i ? access_error_flag : slave_alarm_flag, "flag");
        clr();
      end
    end
  endtask
  task automatic t_bulk;
    logic [15:0] code;
    begin
      @(posedge clk);
      lat <= 4'h1;
      for (int i = 0; i < 4; i++)
      begin
        code = BULK_FIRST + 16'(i);
        wr(OFS_BULK, code);
        repeat (2) @(posedge clk);
        wt();
        chk(read_data_word === (code ^ 16'h5a5a), "bulk");
        chk(slv_bulk === 1'b1 && slv_sel === code, "bulk group");
      end
    end
  endtask
  task automatic t_msg;
    begin
      msg(HDR_READ, 1'b0);
      chk(read_data_word === 16'h5858, "message read");
      msg(HDR_WRITE, 1'b0);
      msg(16'h1506, 1'b1);
      chk(error_info_word === ERR_HDR, "header code");
      clr();
      // Stored direction is still the bad one from the error scenario
      wr(OFS_DIR, DIR_READ);
      @(posedge clk);
      access_request_bit <= 1'b1;
      msg(HDR_READ, 1'b1);
      chk(!access_error_flag, "busy set flag");
      wt();
      @(posedge clk);
      access_request_bit <= 1'b0;
    end
  endtask
  // Main sequence after an 8-cycle reset
  initial
  begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk(access_done_flag === 1'b0, "reset done");
    t_read();
    t_err();
    t_bulk();
    t_msg();
    give_verdict();
  end
  // Watchdog well beyond the few hundred cycles expected
  initial
  begin
    #200000;
    err_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
